// ===== src/mpg_pkg.sv
package mpg_pkg;

    // ========================================
    // pin function selects for the shared pin
    // ========================================
    localparam logic [1:0] SHR_SENSE  = 2'h0;
    localparam logic [1:0] SHR_DECODE = 2'h1;
    localparam logic [1:0] SHR_IRQ    = 2'h2;

    // ========================================
    // decode block sizes
    // ========================================
    localparam logic [1:0] BLK_1  = 2'h0;
    localparam logic [1:0] BLK_8  = 2'h1;
    localparam logic [1:0] BLK_16 = 2'h2;

    // ========================================
    // widths and timing
    // ========================================
    localparam int ADDR_W      = 16;
    localparam int NUM_IRQ     = 8;
    localparam int DEV_W       = 3;
    localparam int CLK_FREQ_KHZ = 100_000;
    localparam int PULSE_NS    = 100;
    localparam int PULSE_CYC   =
        (PULSE_NS * CLK_FREQ_KHZ + 999_999) / 1_000_000;
    localparam logic [3:0] PULSE_CYC_W = 4'(PULSE_CYC);
    localparam logic [NUM_IRQ-1:0] IRQ_RST = 8'h00;

    // ========================================
    // carriers
    // ========================================
    typedef struct packed {
        logic [1:0]        shr_func;
        logic [1:0]        blk_size;
        logic [ADDR_W-1:0] blk_base;
        logic [ADDR_W-1:0] game_addr;
        logic              irq_src_ext;
        logic [DEV_W-1:0]  irq_dev_sel;
        logic [DEV_W-1:0]  ext_route_sel;
        logic              epp_ecp_en;
        logic              alt_floppy_mode;
        logic              uart_powered;
        logic              fdd_od_sel;
    } mpg_cfg_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              aen;
    } mpg_bus_t;

    typedef enum logic [2:0] {
        PS_IDLE  = 3'b001,
        PS_PULSE = 3'b010,
        PS_WAIT  = 3'b100
    } mpg_pstate_t;

endpackage : mpg_pkg

// ===== src/mpg_glue.sv
`timescale 1ns/1ps
// Behaviour
// - alt floppy mode samples drive sense
// - active-low decode for 1/8/16 blocks
// - shared pin carries device or external irq
// - pulse low then release in epp/ecp
// - external irq steered to selected output
// - power-good low isolates inputs, floats outputs
// - power-good never alters held configuration
// - game select on address match, aen low
// - ring and uart irqs gated by power
// - floppy on parallel pins always open-drain
// - parallel outputs push-pull in epp/ecp unless floppy selected
module mpg_glue
    import mpg_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               clk_en,
    input  wire logic               ref_clock_in,
    input  wire logic               power_good,
    input  wire mpg_cfg_t           cfg,
    input  wire mpg_bus_t           bus,
    input  wire logic               second_drive_sense_n,
    input  wire logic               external_irq_in,
    input  wire logic [NUM_IRQ-1:0] dev_irq,
    input  wire logic               ring_indicate_n,
    input  wire logic [1:0]         uart_irq,
    input  wire logic               pp_fdd_sel,
    input  wire logic               fdd_out_n,
    output logic                    floppy_status_a,
    output logic                    block_decode_out_n,
    output logic                    shared_oe_n,
    output logic                    game_select_n,
    output logic                    game_oe_n,
    output logic [NUM_IRQ-1:0]      irq_outputs,
    output logic [NUM_IRQ-1:0]      irq_oe_n,
    output logic                    ring_indicate_q,
    output logic [1:0]              uart_irq_q,
    output logic                    pp_pin_out,
    output logic                    pp_pin_oe_n
);

    // ========================================
    // decode helpers
    // ========================================
    function automatic logic blk_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b,
                                     input logic [1:0]        sz);
        logic h;
        h = 1'b0;
        if (sz == BLK_1)
            h = (a == b);
        else if (sz == BLK_8)
            h = (a[ADDR_W-1:3] == b[ADDR_W-1:3]);
        else if (sz == BLK_16)
            h = (a[ADDR_W-1:4] == b[ADDR_W-1:4]);
        return h;
    endfunction : blk_hit

    // ========================================
    // gated inputs
    // ========================================
    // inputs are forced to idle levels while power is bad so nothing
    // downstream toggles
    logic        pg;
    logic        sense_g;
    logic        ext_g;
    logic [NUM_IRQ-1:0] dev_g;
    logic        ring_g;
    logic [1:0]  uirq_g;
    logic        irq_src;
    logic        src_d;
    logic        next_src_d;

    assign pg      = power_good;
    assign sense_g = pg ? second_drive_sense_n : 1'b1;
    assign ext_g   = pg & external_irq_in;
    assign dev_g   = pg ? dev_irq : IRQ_RST;
    assign ring_g  = (pg & cfg.uart_powered) ? ring_indicate_n : 1'b1;
    assign uirq_g  = (pg & cfg.uart_powered) ? uart_irq : 2'h0;

    assign irq_src = cfg.irq_src_ext ? ext_g : dev_g[cfg.irq_dev_sel];

    // ========================================
    // sharing pulse machine
    // ========================================
    mpg_pstate_t pstate;
    mpg_pstate_t next_pstate;
    logic [3:0]  pcnt;
    logic [3:0]  next_pcnt;

    always_comb
    begin
        next_pstate = pstate;
        next_pcnt   = pcnt;
        next_src_d  = irq_src;
        case (pstate)
            PS_IDLE:
            begin
                if (irq_src && !src_d && cfg.epp_ecp_en)
                begin
                    next_pstate = PS_PULSE;
                    next_pcnt   = PULSE_CYC_W;
                end
            end
            PS_PULSE:
            begin
                if (pcnt <= 4'h1)
                    next_pstate = PS_WAIT;
                else
                    next_pcnt = pcnt - 4'h1;
            end
            PS_WAIT:
            begin
                // one pulse per request; rearm only when it drops
                if (!irq_src)
                    next_pstate = PS_IDLE;
            end
            default:
                next_pstate = PS_IDLE;
        endcase
    end

    // ========================================
    // output next values
    // ========================================
    logic               next_fsa;
    logic               next_blk_n;
    logic               next_sh_oe_n;
    logic               next_game_n;
    logic               next_game_oe_n;
    logic [NUM_IRQ-1:0] next_irq;
    logic [NUM_IRQ-1:0] next_irq_oe_n;
    logic               next_ring;
    logic [1:0]         next_uirq;
    logic               next_pp;
    logic               next_pp_oe_n;
    logic               pp_pushpull;

    always_comb
    begin
        next_fsa = floppy_status_a;
        if (pg && cfg.alt_floppy_mode && cfg.shr_func == SHR_SENSE)
            next_fsa = sense_g;

        next_blk_n   = 1'b1;
        next_sh_oe_n = 1'b1;
        if (cfg.shr_func == SHR_DECODE)
        begin
            next_blk_n   = !blk_hit(bus.addr, cfg.blk_base, cfg.blk_size);
            next_sh_oe_n = next_blk_n;
        end
        else if (cfg.shr_func == SHR_IRQ)
        begin
            if (cfg.epp_ecp_en)
            begin
                next_blk_n   = !(next_pstate == PS_PULSE);
                next_sh_oe_n = next_blk_n;
            end
            else
            begin
                next_blk_n   = !irq_src;
                next_sh_oe_n = 1'b0;
            end
        end

        next_game_n = !((bus.addr == cfg.game_addr) && !bus.aen);
        next_game_oe_n = 1'b0;

        next_irq      = IRQ_RST;
        next_irq[cfg.ext_route_sel] = ext_g;
        next_irq_oe_n = ~IRQ_RST;
        next_irq_oe_n[cfg.ext_route_sel] = 1'b0;

        next_ring = ring_g;
        next_uirq = uirq_g;

        pp_pushpull = cfg.epp_ecp_en;
        if (pp_fdd_sel)
            pp_pushpull = 1'b0;
        next_pp      = pp_pushpull ? fdd_out_n : 1'b0;
        next_pp_oe_n = pp_pushpull ? 1'b0 : fdd_out_n;

        if (!pg)
        begin
            next_blk_n     = 1'b1;
            next_sh_oe_n   = 1'b1;
            next_game_n    = 1'b1;
            next_game_oe_n = 1'b1;
            next_irq       = IRQ_RST;
            next_irq_oe_n  = ~IRQ_RST;
            next_pp        = 1'b0;
            next_pp_oe_n   = 1'b1;
        end
    end

    // ========================================
    // registers
    // ========================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pstate             <= PS_IDLE;
            pcnt               <= 4'h0;
            src_d              <= 1'b0;
            floppy_status_a    <= 1'b1;
            block_decode_out_n <= 1'b1;
            shared_oe_n        <= 1'b1;
            game_select_n      <= 1'b1;
            game_oe_n          <= 1'b1;
            irq_outputs        <= IRQ_RST;
            irq_oe_n           <= ~IRQ_RST;
            ring_indicate_q    <= 1'b1;
            uart_irq_q         <= 2'h0;
            pp_pin_out         <= 1'b0;
            pp_pin_oe_n        <= 1'b1;
        end
        else if (clk_en)
        begin
            pstate             <= next_pstate;
            pcnt               <= next_pcnt;
            src_d              <= next_src_d;
            floppy_status_a    <= next_fsa;
            block_decode_out_n <= next_blk_n;
            shared_oe_n        <= next_sh_oe_n;
            game_select_n      <= next_game_n;
            game_oe_n          <= next_game_oe_n;
            irq_outputs        <= next_irq;
            irq_oe_n           <= next_irq_oe_n;
            ring_indicate_q    <= next_ring;
            uart_irq_q         <= next_uirq;
            pp_pin_out         <= next_pp;
            pp_pin_oe_n        <= next_pp_oe_n;
        end
    end

    // ========================================
    // checks
    // ========================================
    // checkers wait one enabled edge, outputs still hold reset values
    logic       chk_armed;
    logic [3:0] pulse_seen;
    logic [3:0] next_pulse_seen;
    always_comb
    begin
        next_pulse_seen = (pstate == PS_PULSE) ? pulse_seen + 4'h1 : 4'h0;
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chk_armed  <= 1'b0;
            pulse_seen <= 4'h0;
        end
        else if (clk_en)
        begin
            chk_armed  <= 1'b1;
            pulse_seen <= next_pulse_seen;
        end
    end

    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n || !chk_armed);
    sequence pulse_start_s;
        clk_en && pstate == PS_IDLE && irq_src && !src_d
        && cfg.epp_ecp_en;
    endsequence
    sequence pulse_body_s;
        pstate == PS_PULSE;
    endsequence
    pulse_len_a: assert property (
        pulse_body_s ##0 (clk_en && next_pstate != PS_PULSE)
        |-> pulse_seen == PULSE_CYC_W - 4'h1)
        else $error("sharing pulse length wrong");
    pulse_drive_a: assert property (
        pulse_start_s and (pg && cfg.shr_func == SHR_IRQ)
        |=> !shared_oe_n && !block_decode_out_n)
        else $error("pulse not driven low");
    pg_float_a: assert property (
        clk_en && !pg |=> game_oe_n && shared_oe_n && pp_pin_oe_n
        && irq_oe_n == ~IRQ_RST)
        else $error("outputs driven while power bad");
    pg_hold_a: assert property (
        !pg |=> $stable(floppy_status_a))
        else $error("status changed while power bad");
    game_sel_a: assert property (
        clk_en && pg && bus.addr == cfg.game_addr && !bus.aen
        |=> !game_select_n)
        else $error("game select missed");
    game_aen_a: assert property (
        clk_en && bus.aen |=> game_select_n)
        else $error("game select during dma");
    blk_dec_a: assert property (
        clk_en && pg && cfg.shr_func == SHR_DECODE
        |=> block_decode_out_n
            == !blk_hit($past(bus.addr), $past(cfg.blk_base),
                        $past(cfg.blk_size)))
        else $error("block decode wrong");
    ext_route_a: assert property (
        clk_en && pg |=> irq_outputs[$past(cfg.ext_route_sel)]
        == $past(external_irq_in))
        else $error("external irq misrouted");
    ring_gate_a: assert property (
        clk_en && !(pg && cfg.uart_powered) |=> ring_indicate_q
        && uart_irq_q == 2'h0)
        else $error("serial signals leak");
    pp_od_a: assert property (
        clk_en && pg && pp_fdd_sel |=> pp_pin_out == 1'b0)
        else $error("floppy pp pin not open-drain");
    pp_pp_a: assert property (
        clk_en && pg && !pp_fdd_sel && cfg.epp_ecp_en |=> !pp_pin_oe_n)
        else $error("epp pin not push-pull");
    sense_a: assert property (
        clk_en && pg && cfg.alt_floppy_mode && cfg.shr_func == SHR_SENSE
        |=> floppy_status_a == $past(second_drive_sense_n))
        else $error("drive sense not reflected");

    // ref_clock_in is the system reference seen as a plain level; the
    // design itself runs from clk
    logic unused_ref;
    assign unused_ref = ref_clock_in;

endmodule : mpg_glue

// ===== verif/mpg_far_end.sv
`timescale 1ns/1ps
module mpg_far_end
(
    output logic      ref_clock_in,
    input  wire logic shared_oe_n,
    input  wire logic block_decode_out_n,
    output wire logic shared_pin
);
    // ========================================
    // reference clock
    // ========================================
    // single 14.318 MHz source
    initial
    begin
        ref_clock_in = 1'b0;
        forever #34.92 ref_clock_in = ~ref_clock_in;
    end

    // ========================================
    // shared pin with board pull-up
    // ========================================
    // released line must read high, never the last driven value
    assign shared_pin = shared_oe_n ? 1'b1 : block_decode_out_n;
endmodule : mpg_far_end

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb
    import mpg_pkg::*;
;
    typedef struct packed {logic [3:0] k; logic v;} mpg_note_t;
    logic               clk, arst_n, power_good, sense_n, ext_irq;
    logic               ring_n, pp_fdd_sel, fdd_out_n, ref_clk, shared_pin;
    mpg_cfg_t           cfg;
    mpg_bus_t           bus;
    logic [NUM_IRQ-1:0] dev_irq, irq_out, irq_oe_n;
    logic [1:0]         uart_irq, uart_q;
    logic               fsa, dec_n, sh_oe_n, game_n, game_oe_n;
    logic               ring_q, pp_out, pp_oe_n, clk_en;
    logic [31:0]        r;
    int                 fails, check_count, cycles;
    mpg_note_t          q[$];
    event               ev;
    string nm [12] = '{"fsa", "shared_pin", "shared_oe_n", "game_n",
        "game_oe_n", "ring_q", "uart_q0", "pp_oe_n", "irq_sel",
        "irq_oe_sel", "irq_oe_all", "pp_out"};

    mpg_glue u_mpg_glue (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
        .ref_clock_in(ref_clk), .power_good(power_good), .cfg(cfg),
        .bus(bus), .second_drive_sense_n(sense_n),
        .external_irq_in(ext_irq), .dev_irq(dev_irq),
        .ring_indicate_n(ring_n), .uart_irq(uart_irq),
        .pp_fdd_sel(pp_fdd_sel), .fdd_out_n(fdd_out_n),
        .floppy_status_a(fsa), .block_decode_out_n(dec_n),
        .shared_oe_n(sh_oe_n), .game_select_n(game_n),
        .game_oe_n(game_oe_n), .irq_outputs(irq_out),
        .irq_oe_n(irq_oe_n), .ring_indicate_q(ring_q),
        .uart_irq_q(uart_q), .pp_pin_out(pp_out), .pp_pin_oe_n(pp_oe_n));
    mpg_far_end u_mpg_far_end (.ref_clock_in(ref_clk),
        .shared_oe_n(sh_oe_n), .block_decode_out_n(dec_n),
        .shared_pin(shared_pin));

    // ========================================
    // helpers
    // ========================================
    always #5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic got(input logic [3:0] k);
        case (k)
            0: return fsa;
            1: return shared_pin;
            2: return sh_oe_n;
            3: return game_n;
            4: return game_oe_n;
            5: return ring_q;
            6: return uart_q[0];
            7: return pp_oe_n;
            8: return irq_out[cfg.ext_route_sel];
            9: return irq_oe_n[cfg.ext_route_sel];
            10: return &irq_oe_n;
            default: return pp_out;
        endcase
    endfunction : got
    task automatic ap(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : ap
    task automatic note(input logic [3:0] k, input logic v);
        q.push_back({k, v});
        ->ev;
    endtask : note
    task automatic cmp_bit(input string n, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask : cmp_bit
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    // ========================================
    // watcher and timeout
    // ========================================
    always @(ev)
    begin
        mpg_note_t n;
        while (q.size() != 0)
        begin
            n = q.pop_front();
            cmp_bit(nm[n.k], n.v, got(n.k));
        end
    end
    // ceiling well above the hundred or so cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            final_report();
        end
    end

    // ========================================
    // stimulus
    // ========================================
    initial
    begin
        clk = 0; arst_n = 0; power_good = 1; cfg = '0; bus = '0; clk_en = 1;
        sense_n = 1; ext_irq = 1; dev_irq = '0; ring_n = 0;
        uart_irq = 2'h1; pp_fdd_sel = 1; fdd_out_n = 0; r = 32'hb101;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        cfg.alt_floppy_mode <= 1; cfg.epp_ecp_en <= 1;
        cfg.uart_powered <= 1; sense_n <= 0;
        ap(2); note(0, 0);
        note(7, 0); note(4, 0); note(5, 0); note(6, 1);
        @(posedge clk); fdd_out_n <= 1; ap(1); note(7, 1);
        note(11, 0);
        @(posedge clk); pp_fdd_sel <= 0; ap(1); note(7, 0);
        note(11, 1);
        // a low enable must freeze the push-pull level
        @(posedge clk); clk_en <= 0; fdd_out_n <= 0; ap(1);
        note(11, 1);
        @(posedge clk); power_good <= 0; sense_n <= 1; clk_en <= 1; ap(1);
        note(0, 0);
        note(4, 1); note(7, 1); note(10, 1); note(2, 1);
        note(5, 1); note(6, 0);
        @(posedge clk); power_good <= 1; cfg.uart_powered <= 0; ap(1);
        note(0, 1); note(5, 1); note(6, 0);
        @(posedge clk); cfg.shr_func <= SHR_DECODE; cfg.epp_ecp_en <= 0;
        cfg.blk_base <= 16'h0300; cfg.game_addr <= 16'h0201;
        for (int i = 0; i < 3; i++)
        begin
            int sz;
            sz = (i == 0) ? 1 : (i == 1) ? 8 : 16;
            @(posedge clk); cfg.blk_size <= 2'(i);
            bus.addr <= 16'h0300 + 16'(sz - 1);
            ap(1); note(1, 0); note(2, 0);
            @(posedge clk); bus.addr <= 16'h0300 + 16'(sz);
            ap(1); note(1, 1);
        end
        @(posedge clk); bus.addr <= 16'h0201; ap(1); note(3, 0);
        @(posedge clk); bus.aen <= 1; ap(1); note(3, 1);
        @(posedge clk); bus <= '{16'h0203, 1'b0}; ap(1); note(3, 1);
        for (int s = 0; s < NUM_IRQ; s++)
        begin
            @(posedge clk); cfg.ext_route_sel <= DEV_W'(s);
            ap(1); note(8, 1); note(9, 0);
        end
        @(posedge clk); cfg.shr_func <= SHR_IRQ;
        for (int k = 0; k < NUM_IRQ; k++)
        begin
            r = lfsr(r);
            @(posedge clk); cfg.irq_dev_sel <= DEV_W'(k);
            dev_irq <= r[7:0];
            ap(1); note(1, ~r[k]); note(2, 0);
        end
        @(posedge clk); cfg.irq_src_ext <= 1; ext_irq <= 0; ap(1);
        note(1, 1); note(8, 0);
        @(posedge clk); cfg.epp_ecp_en <= 1; ap(3);
        @(posedge clk); ext_irq <= 1; ap(1); note(1, 0); note(2, 0);
        ap(PULSE_CYC - 1); note(1, 0);
        ap(1); note(2, 1); note(1, 1);
        ap(5); note(2, 1);
        ap(2);
        final_report();
    end
endmodule : tb
